// File: core/pll_prog_pkg.sv
// Purpose: shared constants for the synthesizer divider core and its serial programmer
// Assumes: serial words are sent least significant bit first
// Notes:   field positions give the word bit that holds the top bit of each field
package pll_prog_pkg;
    // word sizes
    localparam int FREQ_BITS    = 20;
    localparam int ENH_BITS     = 8;
    localparam int REF_BITS     = 6;
    localparam int MAIN_BITS    = 9;
    localparam int SWALLOW_BITS = 4;

    // frequency word: fields are stored top bit first in rising word order
    localparam int REF_HI_POS   = 0;
    localparam int REF_HI_LEN   = 2;
    localparam int MAIN_HI_POS  = 2;
    localparam int MAIN_HI_LEN  = 2;
    localparam int UNUSED_POS   = 4;
    localparam int MAIN_LO_POS  = 5;
    localparam int MAIN_LO_LEN  = 7;
    localparam int REF_LO_POS   = 12;
    localparam int REF_LO_LEN   = 4;
    localparam int SWALLOW_POS  = 16;

    // enhancement word bits
    localparam int ENH_MAIN_PROBE = 2;
    localparam int ENH_POWER_DOWN = 3;
    localparam int ENH_LOAD       = 4;
    localparam int ENH_MODULUS_SELECT_PROBE = 5;
    localparam int ENH_REF_PROBE  = 6;
    localparam int ENH_BYPASS     = 7;

    // prescaler terminal counts for divide by 10 and by 11
    localparam logic [3:0] PRESCALE_TC_LOW  = 4'h9;
    localparam logic [3:0] PRESCALE_TC_HIGH = 4'hA;

    // reset values
    localparam logic [FREQ_BITS-1:0] FREQ_RESET = 20'h00000;
    localparam logic [ENH_BITS-1:0]  ENH_RESET  = 8'h00;

    // serial timing: half period of the serial clock
    localparam int CORE_PERIOD_NS  = 50;
    localparam int HALF_MIN_NS     = 30;
    localparam int HALF_CYCLES     = (HALF_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS + 1;
    localparam int SYNC_STAGES     = 2;

    function automatic logic [REF_BITS-1:0] ref_field(input logic [FREQ_BITS-1:0] w);
        logic [REF_BITS-1:0] r;
        r = '0;
        for (int i = 0; i < REF_HI_LEN; i++) begin
            r[REF_BITS-1-i] = w[REF_HI_POS+i];
        end
        for (int i = 0; i < REF_LO_LEN; i++) begin
            r[REF_LO_LEN-1-i] = w[REF_LO_POS+i];
        end
        return r;
    endfunction : ref_field

    function automatic logic [MAIN_BITS-1:0] main_field(input logic [FREQ_BITS-1:0] w);
        logic [MAIN_BITS-1:0] m;
        m = '0;
        for (int i = 0; i < MAIN_HI_LEN; i++) begin
            m[MAIN_BITS-1-i] = w[MAIN_HI_POS+i];
        end
        for (int i = 0; i < MAIN_LO_LEN; i++) begin
            m[MAIN_LO_LEN-1-i] = w[MAIN_LO_POS+i];
        end
        return m;
    endfunction : main_field

    function automatic logic [SWALLOW_BITS-1:0] swallow_field(input logic [FREQ_BITS-1:0] w);
        logic [SWALLOW_BITS-1:0] a;
        a = '0;
        for (int i = 0; i < SWALLOW_BITS; i++) begin
            a[SWALLOW_BITS-1-i] = w[SWALLOW_POS+i];
        end
        return a;
    endfunction : swallow_field
endpackage : pll_prog_pkg

// File: core/pll_prog_if.sv
// Purpose: four-wire programming link between controller and synthesizer core
// Assumes: controller makes the serial clock
// Notes:   all wires are one-way, no turnaround
`timescale 1ns/1ps
interface pll_prog_if;
    logic serial_clk;
    logic serial_data;
    logic freq_wr;
    logic enh_wr;

    modport device (
        input serial_clk,
        input serial_data,
        input freq_wr,
        input enh_wr
    );
    modport controller (
        output serial_clk,
        output serial_data,
        output freq_wr,
        output enh_wr
    );
endinterface : pll_prog_if

// File: core/pll_divider_core.sv
// Purpose: divider chain, reference divider and programming registers of the synthesizer
// Assumes: i_core_clk stands for the RF input; i_ref_in is a pin sampled by it
// Notes:   serial shifting runs on the link clock, registers and counters on i_core_clk
// Summary of operation
// - prescaler divides by ten or eleven
// - prescaled ratio is 10(main+1)+swallow
// - programmer keeps main 1..511, swallow<=main+1
// - swallow counter accepts values to 15
// - main value one gives ratio twenty, or two in bypass
// - bypass stops prescaler, ratio main+1
// - bypass only from serial enhancement register
// - six-bit reference divider, ratio ref+1
// - reference value zero passes input through
// - interface select low means serial programming
// - enhancement strobe low shifts twenty bits
// - frequency strobe rise loads frequency register
// - enhancement strobe high shifts eight bits
// - enhancement bits act only while pin low
// - interface select high takes values from pins
// - frequency word bit map as packaged
// - enhancement word bit map as packaged
// - probe bits steer diagnostic output
// - power down stops counters; load continuous
`timescale 1ns/1ps
module pll_divider_core (
    // clock and reset
    input  wire logic                              i_core_clk,
    input  wire logic                              i_rstn,
    // programming link
    pll_prog_if.device                             link,
    // mode pins
    input  wire logic                              i_interface_select,
    input  wire logic                              i_enhancement_active_n,
    input  wire logic                              i_ref_in,
    // direct programming pins
    input  wire logic [pll_prog_pkg::REF_BITS-1:0]     i_direct_ref,
    input  wire logic [pll_prog_pkg::MAIN_BITS-1:0]    i_direct_main,
    input  wire logic [pll_prog_pkg::SWALLOW_BITS-1:0] i_direct_swallow,
    // divider outputs
    output logic                                   o_main_out,
    output logic                                   o_ref_out,
    output logic                                   o_modulus_select,
    output logic                                   o_diag_out
);
    localparam int PIN_W = 4 + pll_prog_pkg::REF_BITS + pll_prog_pkg::MAIN_BITS + pll_prog_pkg::SWALLOW_BITS + 1;

    // link domain holding buffers
    logic [pll_prog_pkg::FREQ_BITS-1:0] freq_buf;
    logic [pll_prog_pkg::ENH_BITS-1:0]  enh_buf;

    always_ff @(posedge link.serial_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            freq_buf <= pll_prog_pkg::FREQ_RESET;
            enh_buf  <= pll_prog_pkg::ENH_RESET;
        end else if (link.enh_wr) begin
            enh_buf <= {link.serial_data, enh_buf[pll_prog_pkg::ENH_BITS-1:1]};
        end else begin
            freq_buf <= {link.serial_data, freq_buf[pll_prog_pkg::FREQ_BITS-1:1]};
        end
    end

    // pin and strobe synchronisers; stage 1 feeds only stage 2
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [2:0]       edge_s3;
    assign pin_raw = {link.freq_wr, link.enh_wr, i_ref_in, i_interface_select, i_enhancement_active_n,
                      i_direct_ref, i_direct_main, i_direct_swallow};

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_s1  <= '0;
            pin_s2  <= '0;
            edge_s3 <= 3'h0;
        end else begin
            pin_s1  <= pin_raw;
            pin_s2  <= pin_s1;
            edge_s3 <= pin_s2[PIN_W-1:PIN_W-3];
        end
    end

    logic                                   freq_wr_s;
    logic                                   enh_wr_s;
    logic                                   ref_s;
    logic                                   mode_s;
    logic                                   enh_n_s;
    logic [pll_prog_pkg::REF_BITS-1:0]      pin_ref;
    logic [pll_prog_pkg::MAIN_BITS-1:0]     pin_main;
    logic [pll_prog_pkg::SWALLOW_BITS-1:0]  pin_swallow;
    assign {freq_wr_s, enh_wr_s, ref_s, mode_s, enh_n_s, pin_ref, pin_main, pin_swallow} = pin_s2;

    // buffers are quiet while a strobe is active, so they cross as stable words
    logic [pll_prog_pkg::FREQ_BITS-1:0] frequency_control_reg;
    logic [pll_prog_pkg::ENH_BITS-1:0]  enhancement_reg;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            frequency_control_reg <= pll_prog_pkg::FREQ_RESET;
        end else if (freq_wr_s && !edge_s3[2]) begin
            frequency_control_reg <= freq_buf;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            enhancement_reg <= pll_prog_pkg::ENH_RESET;
        end else if (!enh_wr_s && edge_s3[1]) begin
            enhancement_reg <= enh_buf;
        end
    end

    logic [pll_prog_pkg::ENH_BITS-1:0]     enh_eff;
    logic                                  bypass;
    logic                                  power_down;
    logic                                  load_now;
    logic [pll_prog_pkg::REF_BITS-1:0]     sel_ref;
    logic [pll_prog_pkg::MAIN_BITS-1:0]    sel_main;
    logic [pll_prog_pkg::SWALLOW_BITS-1:0] sel_swallow;

    always_comb begin
        enh_eff    = enh_n_s ? pll_prog_pkg::ENH_RESET : enhancement_reg;
        bypass     = !mode_s && enh_eff[pll_prog_pkg::ENH_BYPASS];
        power_down = enh_eff[pll_prog_pkg::ENH_POWER_DOWN];
        load_now   = enh_eff[pll_prog_pkg::ENH_LOAD];
        if (mode_s) begin
            sel_ref     = pin_ref;
            sel_main    = pin_main;
            sel_swallow = pin_swallow;
        end else begin
            sel_ref     = pll_prog_pkg::ref_field(frequency_control_reg);
            sel_main    = pll_prog_pkg::main_field(frequency_control_reg);
            sel_swallow = pll_prog_pkg::swallow_field(frequency_control_reg);
        end
    end

    // working values are taken at the end of a division, or on every cycle while the load bit is set
    logic [pll_prog_pkg::MAIN_BITS-1:0]    work_main;
    logic [pll_prog_pkg::SWALLOW_BITS-1:0] work_swallow;
    logic [pll_prog_pkg::REF_BITS-1:0]     work_ref;
    logic [3:0]                            pre_cnt;
    logic [pll_prog_pkg::MAIN_BITS-1:0]    main_cnt;
    logic [pll_prog_pkg::SWALLOW_BITS-1:0] swal_cnt;
    logic [pll_prog_pkg::REF_BITS-1:0]     ref_cnt;
    logic                                  pre_wrap;
    logic                                  main_wrap;
    logic                                  ref_edge;
    logic                                  ref_wrap;

    assign pre_wrap  = bypass || (pre_cnt == (o_modulus_select ? pll_prog_pkg::PRESCALE_TC_HIGH
                                                                : pll_prog_pkg::PRESCALE_TC_LOW));
    assign main_wrap = pre_wrap && (main_cnt == work_main);
    assign ref_edge  = ref_s && !edge_s3[0];
    assign ref_wrap  = ref_edge && (ref_cnt == work_ref);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            work_main    <= '0;
            work_swallow <= '0;
            work_ref     <= '0;
        end else begin
            if (load_now || main_wrap) begin
                work_main    <= sel_main;
                work_swallow <= sel_swallow;
            end
            if (load_now || ref_wrap || work_ref == '0) begin
                work_ref <= sel_ref;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_cnt          <= 4'h0;
            main_cnt         <= '0;
            swal_cnt         <= '0;
            o_main_out       <= 1'b0;
            o_modulus_select <= 1'b0;
        end else if (power_down || bypass) begin
            // prescaler and swallow counter held off in bypass and power down
            pre_cnt          <= 4'h0;
            swal_cnt         <= '0;
            o_modulus_select <= 1'b0;
            if (power_down) begin
                main_cnt   <= '0;
                o_main_out <= 1'b0;
            end else begin
                main_cnt   <= main_wrap ? '0 : main_cnt + 1'b1;
                o_main_out <= main_wrap;
            end
        end else begin
            pre_cnt <= pre_wrap ? 4'h0 : pre_cnt + 4'h1;
            if (pre_wrap) begin
                o_main_out <= main_wrap;
                if (main_wrap) begin
                    main_cnt         <= '0;
                    swal_cnt         <= '0;
                    o_modulus_select <= (sel_swallow != '0);
                end else begin
                    main_cnt         <= main_cnt + 1'b1;
                    swal_cnt         <= (swal_cnt == '1) ? swal_cnt : swal_cnt + 1'b1;
                    o_modulus_select <= ({1'b0, swal_cnt} + 5'h01) < {1'b0, work_swallow};
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_cnt   <= '0;
            o_ref_out <= 1'b0;
        end else if (power_down) begin
            ref_cnt   <= '0;
            o_ref_out <= 1'b0;
        end else if (work_ref == '0) begin
            ref_cnt   <= '0;
            o_ref_out <= ref_s;
        end else if (ref_edge) begin
            ref_cnt   <= ref_wrap ? '0 : ref_cnt + 1'b1;
            o_ref_out <= ref_wrap;
        end
    end

    // probe select; first set probe wins
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_diag_out <= 1'b0;
        end else if (enh_eff[pll_prog_pkg::ENH_MAIN_PROBE]) begin
            o_diag_out <= o_main_out;
        end else if (enh_eff[pll_prog_pkg::ENH_MODULUS_SELECT_PROBE]) begin
            o_diag_out <= o_modulus_select;
        end else if (enh_eff[pll_prog_pkg::ENH_REF_PROBE]) begin
            o_diag_out <= o_ref_out;
        end else begin
            o_diag_out <= 1'b0;
        end
    end
endmodule : pll_divider_core

// File: core/pll_prog_controller.sv
// Purpose: controller end that writes frequency or enhancement words over the four-wire link
// Assumes: one request at a time; i_start is ignored while busy
// Notes:   serial clock is derived from i_core_clk and only runs during a transfer
`timescale 1ns/1ps
module pll_prog_controller (
    // clock and reset
    input  wire logic                                 i_core_clk,
    input  wire logic                                 i_rstn,
    // user request
    input  wire logic                                 i_start,
    input  wire logic                                 i_select_enh,
    input  wire logic [pll_prog_pkg::FREQ_BITS-1:0]   i_word,
    // user status
    output logic                                      o_busy,
    output logic                                      o_done,
    // programming link
    pll_prog_if.controller                            link
);
    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL, ST_STROBE, ST_GAP} state_t;

    state_t                             state;
    logic [pll_prog_pkg::FREQ_BITS-1:0] shreg;
    logic [4:0]                         bits_left;
    logic [2:0]                         tmr;
    logic                               is_enh;
    logic                               tmr_done;

    localparam logic [2:0] HALF = 3'(pll_prog_pkg::HALF_CYCLES - 1);

    assign tmr_done = (tmr == 3'h0);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state            <= ST_IDLE;
            shreg            <= pll_prog_pkg::FREQ_RESET;
            bits_left        <= 5'h00;
            tmr              <= 3'h0;
            is_enh           <= 1'b0;
            o_busy           <= 1'b0;
            o_done           <= 1'b0;
            link.serial_clk  <= 1'b0;
            link.serial_data <= 1'b0;
            link.freq_wr     <= 1'b0;
            link.enh_wr      <= 1'b0;
        end else begin
            o_done <= 1'b0;
            tmr    <= tmr_done ? HALF : tmr - 3'h1;
            unique case (state)
                ST_IDLE: begin
                    tmr <= HALF;
                    if (i_start) begin
                        shreg       <= i_word;
                        is_enh      <= i_select_enh;
                        bits_left   <= i_select_enh ? 5'(pll_prog_pkg::ENH_BITS) : 5'(pll_prog_pkg::FREQ_BITS);
                        link.enh_wr <= i_select_enh;
                        o_busy      <= 1'b1;
                        state       <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (tmr_done) begin
                        link.serial_data <= shreg[0];
                        state            <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (tmr_done) begin
                        link.serial_clk <= 1'b1;
                        state           <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (tmr_done) begin
                        link.serial_clk  <= 1'b0;
                        shreg            <= {1'b0, shreg[pll_prog_pkg::FREQ_BITS-1:1]};
                        link.serial_data <= shreg[1];
                        bits_left        <= bits_left - 5'h01;
                        state            <= (bits_left == 5'h01) ? ST_TAIL : ST_LOW;
                    end
                end
                ST_TAIL: begin
                    if (tmr_done) begin
                        // end the transfer with the right strobe edge
                        if (is_enh) begin
                            link.enh_wr <= 1'b0;
                            state       <= ST_GAP;
                        end else begin
                            link.freq_wr <= 1'b1;
                            state        <= ST_STROBE;
                        end
                    end
                end
                ST_STROBE: begin
                    if (tmr_done) begin
                        link.freq_wr <= 1'b0;
                        state        <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // gap lets the core synchronisers see the strobe before the next word
                    if (tmr_done) begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        state  <= ST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : pll_prog_controller

// File: bench/pll_link_checker.sv
// Purpose: link wire checks between serial controller and divider core
// Assumes: link wires are launched from core clock registers
// Notes:   bit counter restarts on enhancement strobe edges and frequency strobe falls, so stray clock pulses show up
`timescale 1ns/1ps
module pll_link_checker (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // link wires
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic freq_wr,
    input wire logic enh_wr
);
    logic [4:0] bit_cnt;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bit_cnt <= 5'h00;
        end else if ($changed(enh_wr) || $fell(freq_wr)) begin
            bit_cnt <= 5'h00;
        end else if ($rose(serial_clk)) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    AST_FREQ_COUNT: assert property ($rose(freq_wr) |-> bit_cnt == 5'h14)
        else $error("frequency strobe after wrong bit count");
    AST_ENH_COUNT: assert property ($fell(enh_wr) |-> bit_cnt == 5'h08)
        else $error("enhancement strobe after wrong bit count");
    AST_CLK_HIGH: assert property ($rose(serial_clk) |-> serial_clk [*2] ##1 !serial_clk)
        else $error("serial clock high phase wrong");
    AST_CLK_LOW: assert property ($fell(serial_clk) |-> !serial_clk [*2])
        else $error("serial clock low phase too short");
    AST_DATA_HOLD: assert property ($rose(serial_clk) |-> $stable(serial_data) ##1 $stable(serial_data))
        else $error("serial data moved around clock rise");
    AST_ENH_EDGE: assert property ($changed(enh_wr) |-> !serial_clk && !$past(serial_clk))
        else $error("enhancement strobe moved with clock high");
    AST_FREQ_QUIET: assert property (freq_wr |-> !serial_clk && !enh_wr)
        else $error("activity during frequency strobe");
    AST_FREQ_WIDTH: assert property ($rose(freq_wr) |-> freq_wr [*2] ##1 !freq_wr)
        else $error("frequency strobe width wrong");
    AST_ENH_QUIET: assert property ($fell(enh_wr) |-> !serial_clk [*3])
        else $error("serial clock too soon after enhancement strobe");
endmodule : pll_link_checker

// File: bench/test_pll_divider_and_program_port.sv
// Purpose: controller and divider core joined over the link, user sides driven
// Assumes: core clock stands for the RF input; main ratios counted in core cycles, reference ratios in reference rises
// Notes:   ratios measured twice since new values land at a division end
`timescale 1ns/1ps
module test_pll_divider_and_program_port;
    logic        i_core_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_start = 1'b0;
    logic        i_select_enh = 1'b0;
    logic [19:0] i_word = 20'h00000;
    logic        i_interface_select = 1'b0;
    logic        i_enhancement_active_n = 1'b0;
    logic        i_ref_in = 1'b0;
    logic [5:0]  i_direct_ref = 6'h00;
    logic [8:0]  i_direct_main = 9'h007;
    logic [3:0]  i_direct_swallow = 4'h0;
    logic        o_busy, o_done, o_main_out, o_ref_out, o_modulus_select, o_diag_out;
    logic [19:0] cap = 20'h00000;
    int          fail_count = 0;
    int          compares = 0;

    pll_prog_if link_if ();
    pll_prog_controller pll_prog_controller_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(i_start),
        .i_select_enh(i_select_enh), .i_word(i_word), .o_busy(o_busy), .o_done(o_done), .link(link_if));
    pll_divider_core pll_divider_core_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .link(link_if),
        .i_interface_select(i_interface_select), .i_enhancement_active_n(i_enhancement_active_n),
        .i_ref_in(i_ref_in), .i_direct_ref(i_direct_ref), .i_direct_main(i_direct_main),
        .i_direct_swallow(i_direct_swallow), .o_main_out(o_main_out), .o_ref_out(o_ref_out),
        .o_modulus_select(o_modulus_select), .o_diag_out(o_diag_out));
    pll_link_checker pll_link_checker_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .serial_clk(link_if.serial_clk), .serial_data(link_if.serial_data),
        .freq_wr(link_if.freq_wr), .enh_wr(link_if.enh_wr));

    always #25 i_core_clk = ~i_core_clk;
    always begin
        repeat (3) @(negedge i_core_clk);
        i_ref_in = ~i_ref_in;
    end
    // wire-side copy of the bits, newest at the top
    always @(posedge link_if.serial_clk) cap <= {link_if.serial_data, cap[19:1]};

    task automatic conclude();
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check

    function automatic logic [19:0] fw(input logic [8:0] m, input logic [3:0] a, input logic [5:0] r);
        return {a[0], a[1], a[2], a[3], r[0], r[1], r[2], r[3], m[0], m[1], m[2], m[3], m[4], m[5], m[6],
                1'b0, m[7], m[8], r[4], r[5]};
    endfunction : fw

    function automatic logic pick(input int sel);
        return (sel == 0) ? o_main_out : (sel == 1) ? o_modulus_select : (sel == 2) ? o_ref_out : 1'b0;
    endfunction : pick

    task automatic send(input logic enhancement_active_n, input logic [19:0] w);
        @(negedge i_core_clk);
        i_start = 1'b1;
        i_select_enh = enhancement_active_n;
        i_word = w;
        @(negedge i_core_clk);
        i_start = 1'b0;
        check(o_busy, 1'b1);
        for (int k = 0; k < 400 && o_done !== 1'b1; k++) @(negedge i_core_clk);
        check(o_done, 1'b1);
        check(o_busy, 1'b0);
        if (enhancement_active_n) check({12'h000, cap[19:12]}, {12'h000, w[7:0]});
        else check(cap, w);
    endtask : send

    // core cycles (or reference rises) between output rises, plus modulus-select high cycles
    task automatic ratio(input bit use_ref, input int exp, input int exp_hi);
        int cnt;
        int hi;
        int got;
        int got_hi;
        logic prev;
        logic rp;
        logic s;
        repeat (2) begin
            cnt = -1;
            hi = 0;
            got = 0;
            got_hi = 0;
            prev = 1'b1;
            rp = i_ref_in;
            for (int k = 0; k < 1500 && got == 0; k++) begin
                @(negedge i_core_clk);
                s = use_ref ? o_ref_out : o_main_out;
                if (cnt >= 0) cnt += use_ref ? int'(i_ref_in === 1'b1 && rp === 1'b0) : 1;
                if (cnt >= 0) hi += int'(o_modulus_select === 1'b1);
                if (s === 1'b1 && prev === 1'b0 && cnt >= 0) got = cnt;
                // hi is cleared at the closing rise, so keep its count first
                if (s === 1'b1 && prev === 1'b0 && cnt >= 0) got_hi = hi;
                if (s === 1'b1 && prev === 1'b0) cnt = 0;
                if (s === 1'b1 && prev === 1'b0) hi = 0;
                prev = s;
                rp = i_ref_in;
            end
        end
        check(got, exp);
        if (exp_hi >= 0) check(got_hi, exp_hi);
    endtask : ratio

    task automatic probe(input logic [7:0] enhancement_active_n, input int sel);
        logic prev;
        int bad;
        send(1'b1, {12'h000, enhancement_active_n});
        repeat (4) @(negedge i_core_clk);
        prev = pick(sel);
        bad = 0;
        repeat (200) begin
            @(negedge i_core_clk);
            bad += int'(o_diag_out !== prev);
            prev = pick(sel);
        end
        check(bad, 0);
    endtask : probe

    task automatic t_prescaled();
        send(1'b0, fw(9'h001, 4'h0, 6'h00));
        ratio(0, 20, 0);
        send(1'b0, fw(9'h003, 4'h2, 6'h00));
        ratio(0, 42, 22);
        send(1'b0, fw(9'h00E, 4'hF, 6'h00));
        ratio(0, 165, 165);
    endtask : t_prescaled

    task automatic t_reference();
        ratio(1, 1, -1);
        send(1'b0, fw(9'h001, 4'h0, 6'h03));
        ratio(1, 4, -1);
        send(1'b0, fw(9'h001, 4'h0, 6'h3F));
        ratio(1, 64, -1);
    endtask : t_reference

    task automatic t_bypass();
        send(1'b1, 20'h00080);
        send(1'b0, fw(9'h005, 4'h3, 6'h00));
        ratio(0, 6, -1);
        i_enhancement_active_n = 1'b1;
        ratio(0, 63, 33);
        i_enhancement_active_n = 1'b0;
        i_interface_select = 1'b1;
        ratio(0, 80, 0);
        i_interface_select = 1'b0;
        ratio(0, 6, -1);
    endtask : t_bypass

    task automatic t_probe();
        send(1'b0, fw(9'h003, 4'h2, 6'h01));
        probe(8'h04, 0);
        probe(8'h20, 1);
        probe(8'h40, 2);
        probe(8'h00, 3);
        send(1'b1, 20'h00008);
        ratio(0, 0, -1);
        send(1'b0, fw(9'h001, 4'h0, 6'h00));
        send(1'b1, 20'h00000);
        ratio(0, 20, 0);
        // counter load: only raise the main value so the running count never overshoots
        send(1'b1, 20'h00010);
        send(1'b0, fw(9'h002, 4'h1, 6'h00));
        ratio(0, 31, 11);
    endtask : t_probe

    initial begin
        repeat (10) @(negedge i_core_clk);
        i_rstn = 1'b1;
        t_prescaled();
        t_reference();
        t_bypass();
        t_probe();
        conclude();
    end

    // roughly eight times the expected run length
    initial begin
        #3000000;
        fail_count++;
        conclude();
    end
endmodule : test_pll_divider_and_program_port
